// [supply_limit_monitor.sv]
`timescale 1ns/1ps
`include "supply_limit_monitor_defines.svh"
module supply_limit_monitor #(
  parameter int MS_CYCLES = `MS_CYCLES_DEFAULT
) (
  // Clock and reset
  input  wire logic                          i_core_clk,
  input  wire logic                          i_rst,
  // Decoded command port
  input  wire supply_limit_monitor_pkg::cmd_t i_cmd,
  output logic [15:0]                        o_rdata,
  output logic                               o_rvalid,
  // Measurements from the converter
  input  wire supply_limit_monitor_pkg::meas_t i_meas,
  input  wire logic [`CHANNELS-1:0]          i_ov_fault,
  input  wire logic [`CHANNELS-1:0]          i_ov_warn,
  input  wire logic [`CHANNELS-1:0]          i_uv_warn,
  input  wire logic                          i_vendor_status_any,
  input  wire logic                          i_margin_fault,
  input  wire logic                          i_comm_fault,
  // Control pins
  input  wire logic [`CHANNELS-1:0]          i_on_off_control_pins,
  input  wire logic                          i_immediate_off_pin,
  // Supply and system outputs
  output logic [`CHANNELS-1:0]               o_supply_enable_out,
  output logic [`CHANNELS-1:0]               o_fault_response,
  output logic                               o_margin_start,
  output logic                               o_alert_oe,
  output logic                               o_ara_enable
);
  localparam int N = `CHANNELS;

  logic [15:0] uv_lim_r [N];
  logic [15:0] ocw_lim_r [N];
  logic [15:0] ocf_lim_r [N];
  logic [15:0] pgon_r [N];
  logic [15:0] pgoff_r [N];
  logic [15:0] ton_d_r [N];
  logic [15:0] ton_max_r [N];
  logic [15:0] toff_d_r [N];
  logic [15:0] pin_cfg_r [N];
  logic [15:0] otf_lim_r, otw_lim_r, mode_r, action_r;

  logic [7:0]  vstat_r [N];
  logic [7:0]  istat_r [N];
  logic [7:0]  tstat_r;

  logic [N-1:0] pg_r, pg_seen_r, pbad_r, uv_act_r, ocw_act_r, ocf_act_r, ocf_arm_r;
  logic         otf_act_r, otw_act_r;
  logic [N-1:0] ton_evt, uv_evt, ocf_evt;
  logic         otf_evt;
  logic [N-1:0] shutdown;

  logic [N-1:0] run_s1_r, run_s2_r, run_d_r;
  logic         imm_s1_r, imm_s2_r;
  logic [N-1:0] pg_d_r;

  supply_limit_monitor_pkg::seq_state_t state_r [N];
  logic [N-1:0] en_r;
  logic [16:0]  ms_cnt_r;
  logic         ms_tick;

  logic [15:0]  status_word;
  logic [15:0]  rd_nxt;
  logic [N-1:0] seq_off;
  logic         alert_src;

  logic              wr;
  logic [`CHAN_W-1:0] pg_sel;
  assign wr     = i_cmd.valid && i_cmd.write;
  assign pg_sel = i_cmd.page;

  // Pins come from outside the clock domain.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      run_s1_r <= '0;
      run_s2_r <= '0;
      imm_s1_r <= 1'b0;
      imm_s2_r <= 1'b0;
    end else begin
      run_s1_r <= i_on_off_control_pins;
      run_s2_r <= run_s1_r;
      imm_s1_r <= i_immediate_off_pin;
      imm_s2_r <= imm_s1_r;
    end
  end

  // Millisecond enable for the delay timers.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      ms_cnt_r <= '0;
    end else if (ms_cnt_r == 17'(MS_CYCLES - 1)) begin
      ms_cnt_r <= '0;
    end else begin
      ms_cnt_r <= ms_cnt_r + 17'd1;
    end
  end
  assign ms_tick = (ms_cnt_r == 17'(MS_CYCLES - 1));

  // Limit and configuration registers.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      for (int c = 0; c < N; c++) begin
        uv_lim_r[c]  <= `LIMIT_RESET;
        ocw_lim_r[c] <= `LIMIT_RESET;
        ocf_lim_r[c] <= `LIMIT_RESET;
        pgon_r[c]    <= `LIMIT_RESET;
        pgoff_r[c]   <= `LIMIT_RESET;
        ton_d_r[c]   <= `LIMIT_RESET;
        ton_max_r[c] <= `LIMIT_RESET;
        toff_d_r[c]  <= `LIMIT_RESET;
        pin_cfg_r[c] <= `LIMIT_RESET;
      end
      otf_lim_r <= `LIMIT_RESET;
      otw_lim_r <= `LIMIT_RESET;
      mode_r    <= `MODE_RESET;
      action_r  <= `MODE_RESET;
    end else if (wr) begin
      case (i_cmd.code)
        `CMD_UV_FAULT_LIMIT: uv_lim_r[pg_sel]  <= i_cmd.wdata;
        `CMD_OC_WARN_LIMIT:  ocw_lim_r[pg_sel] <= i_cmd.wdata;
        `CMD_OC_FAULT_LIMIT: ocf_lim_r[pg_sel] <= i_cmd.wdata;
        `CMD_GOOD_ON:        pgon_r[pg_sel]    <= i_cmd.wdata;
        `CMD_GOOD_OFF:       pgoff_r[pg_sel]   <= i_cmd.wdata;
        `CMD_TURN_ON_DELAY:  ton_d_r[pg_sel]   <= i_cmd.wdata;
        `CMD_TURN_ON_LIMIT:  ton_max_r[pg_sel] <= i_cmd.wdata;
        `CMD_TURN_OFF_DELAY: toff_d_r[pg_sel]  <= i_cmd.wdata;
        `CMD_PIN_CONFIG:     pin_cfg_r[pg_sel] <= i_cmd.wdata;
        `CMD_OVERTEMP_FAULT_LIMIT: otf_lim_r <= i_cmd.wdata;
        `CMD_OVERTEMP_WARN_LIMIT:  otw_lim_r <= i_cmd.wdata;
        `CMD_VENDOR_MODE:    mode_r    <= i_cmd.wdata;
        `CMD_FAULT_ACTION:   action_r  <= i_cmd.wdata;
        default: ;
      endcase
    end
  end

  // Power-good tracking per channel.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      pg_r      <= '0;
      pg_seen_r <= '0;
      pbad_r    <= '1;
    end else begin
      for (int c = 0; c < N; c++) begin
        if (state_r[c] == supply_limit_monitor_pkg::SEQ_OFF) begin
          pg_seen_r[c] <= 1'b0;
        end
      end
      if (i_meas.valid && i_meas.kind == supply_limit_monitor_pkg::MEAS_VOUT) begin
        if (i_meas.value > pgon_r[i_meas.chan]) begin
          pg_r[i_meas.chan]      <= 1'b1;
          pg_seen_r[i_meas.chan] <= 1'b1;
          pbad_r[i_meas.chan]    <= 1'b0;
        end else if (pg_r[i_meas.chan] && i_meas.value < pgoff_r[i_meas.chan]) begin
          pg_r[i_meas.chan]   <= 1'b0;
          pbad_r[i_meas.chan] <= 1'b1;
        end
      end
    end
  end

  // Undervoltage, armed only after first power-good and not while turning off.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      uv_act_r <= '0;
    end else begin
      for (int c = 0; c < N; c++) begin
        if (!pg_seen_r[c] || !en_r[c] || state_r[c] == supply_limit_monitor_pkg::SEQ_OFF_WAIT) begin
          uv_act_r[c] <= 1'b0;
        end
      end
      if (i_meas.valid && i_meas.kind == supply_limit_monitor_pkg::MEAS_VOUT && pg_seen_r[i_meas.chan]
          && en_r[i_meas.chan] && state_r[i_meas.chan] == supply_limit_monitor_pkg::SEQ_ON) begin
        if (i_meas.value < uv_lim_r[i_meas.chan]) begin
          uv_act_r[i_meas.chan] <= 1'b1;
        end else if ({1'b0, i_meas.value} >= {1'b0, uv_lim_r[i_meas.chan]}
                     + {1'b0, uv_lim_r[i_meas.chan] / `VOLT_HYST_DIV}) begin
          uv_act_r[i_meas.chan] <= 1'b0;
        end
      end
    end
  end

  // Overcurrent warning and fault with 5% release band.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      ocw_act_r <= '0;
      ocf_act_r <= '0;
      ocf_arm_r <= '0;
    end else if (i_meas.valid && i_meas.kind == supply_limit_monitor_pkg::MEAS_IOUT) begin
      if (i_meas.value > ocw_lim_r[i_meas.chan]) begin
        ocw_act_r[i_meas.chan] <= 1'b1;
      end else if (i_meas.value <= ocw_lim_r[i_meas.chan] - ocw_lim_r[i_meas.chan] / `CURR_HYST_DIV) begin
        ocw_act_r[i_meas.chan] <= 1'b0;
      end
      if (i_meas.value < ocf_lim_r[i_meas.chan]) begin
        ocf_arm_r[i_meas.chan] <= 1'b1;
      end
      if (ocf_arm_r[i_meas.chan] && i_meas.value > ocf_lim_r[i_meas.chan]) begin
        ocf_act_r[i_meas.chan] <= 1'b1;
      end else if (i_meas.value <= ocf_lim_r[i_meas.chan] - ocf_lim_r[i_meas.chan] / `CURR_HYST_DIV) begin
        ocf_act_r[i_meas.chan] <= 1'b0;
      end
    end
  end

  // Overtemperature with a fixed degree band.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      otf_act_r <= 1'b0;
      otw_act_r <= 1'b0;
    end else if (i_meas.valid && i_meas.kind == supply_limit_monitor_pkg::MEAS_TEMP) begin
      if (i_meas.value > otf_lim_r) begin
        otf_act_r <= 1'b1;
      end else if ({1'b0, i_meas.value} + {1'b0, `TEMP_HYST_DEG} <= {1'b0, otf_lim_r}) begin
        otf_act_r <= 1'b0;
      end
      if (i_meas.value > otw_lim_r) begin
        otw_act_r <= 1'b1;
      end else if ({1'b0, i_meas.value} + {1'b0, `TEMP_HYST_DEG} <= {1'b0, otw_lim_r}) begin
        otw_act_r <= 1'b0;
      end
    end
  end

  // Fault onsets trigger the configured action; warnings do not.
  logic [N-1:0] uv_d_r, ocf_d_r;
  logic         otf_d_r;
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      uv_d_r  <= '0;
      ocf_d_r <= '0;
      otf_d_r <= 1'b0;
    end else begin
      uv_d_r  <= uv_act_r;
      ocf_d_r <= ocf_act_r;
      otf_d_r <= otf_act_r;
    end
  end
  assign uv_evt  = uv_act_r & ~uv_d_r;
  assign ocf_evt = ocf_act_r & ~ocf_d_r;
  assign otf_evt = otf_act_r & ~otf_d_r;

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_fault_response <= '0;
    end else begin
      o_fault_response <= uv_evt | ocf_evt | ton_evt | {N{otf_evt}};
    end
  end
  assign shutdown = (uv_evt | ocf_evt | ton_evt | {N{otf_evt}}) & {N{action_r[`ACTION_SHUTDOWN]}};

  // Latched status bytes; a condition present in the clear cycle sets again.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      for (int c = 0; c < N; c++) begin
        vstat_r[c] <= 8'h00;
        istat_r[c] <= 8'h00;
      end
      tstat_r <= 8'h00;
    end else begin
      for (int c = 0; c < N; c++) begin
        logic [7:0] vclr, iclr, vset, iset;
        vclr = (wr && i_cmd.code == `CMD_VOLTAGE_STATUS && pg_sel == `CHAN_W'(c)) ? i_cmd.wdata[7:0] : 8'h00;
        iclr = (wr && i_cmd.code == `CMD_CURRENT_STATUS && pg_sel == `CHAN_W'(c)) ? i_cmd.wdata[7:0] : 8'h00;
        vset = 8'h00;
        iset = 8'h00;
        vset[`VS_OV_FAULT] = i_ov_fault[c];
        vset[`VS_OV_WARN]  = i_ov_warn[c];
        vset[`VS_UV_WARN]  = i_uv_warn[c];
        vset[`VS_UV_FAULT] = uv_act_r[c];
        vset[`VS_TIMEOUT]  = ton_evt[c];
        iset[`IS_OC_FAULT] = ocf_act_r[c];
        iset[`IS_OC_WARN]  = ocw_act_r[c];
        vstat_r[c] <= (vstat_r[c] & ~vclr) | vset;
        istat_r[c] <= (istat_r[c] & ~iclr) | iset;
      end
      tstat_r[`TS_OT_FAULT] <= (tstat_r[`TS_OT_FAULT] & ~(wr && i_cmd.code == `CMD_TEMP_STATUS
                               && i_cmd.wdata[`TS_OT_FAULT])) | otf_act_r;
      tstat_r[`TS_OT_WARN]  <= (tstat_r[`TS_OT_WARN] & ~(wr && i_cmd.code == `CMD_TEMP_STATUS
                               && i_cmd.wdata[`TS_OT_WARN])) | otw_act_r;
    end
  end

  // Start and stop come from the pins, or from power-good in power-good mode.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      run_d_r <= '0;
      pg_d_r  <= '0;
    end else begin
      run_d_r <= run_s2_r;
      pg_d_r  <= pg_r;
    end
  end

  // Turn-on, turn-off and turn-on timeout sequencer per channel.
  generate
    for (genvar g = 0; g < N; g++) begin : g_seq
      logic [15:0] tcnt_r;
      logic        ton_done_r;
      logic        start, stop, lvl;
      assign lvl   = pin_cfg_r[g][`PIN_GOOD_MODE] ? pg_r[g] : run_s2_r[g];
      assign start = pin_cfg_r[g][`PIN_GOOD_MODE] ? (pg_r[g] & ~pg_d_r[g]) : (run_s2_r[g] & ~run_d_r[g]);
      assign stop  = ~lvl;
      assign ton_evt[g] = (state_r[g] == supply_limit_monitor_pkg::SEQ_ON) && ms_tick && !pg_seen_r[g]
                          && !ton_done_r && ton_max_r[g] != 16'h0000 && tcnt_r + 16'd1 >= ton_max_r[g];

      always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
          state_r[g]  <= supply_limit_monitor_pkg::SEQ_OFF;
          en_r[g]     <= 1'b0;
          tcnt_r      <= 16'h0000;
          ton_done_r  <= 1'b0;
        end else if (imm_s2_r || shutdown[g]) begin
          state_r[g] <= supply_limit_monitor_pkg::SEQ_OFF;
          en_r[g]    <= 1'b0;
        end else begin
          case (state_r[g])
            supply_limit_monitor_pkg::SEQ_OFF: begin
              tcnt_r     <= 16'h0000;
              ton_done_r <= 1'b0;
              if (start) begin
                if (ton_d_r[g] == 16'h0000) begin
                  state_r[g] <= supply_limit_monitor_pkg::SEQ_ON;
                  en_r[g]    <= 1'b1;
                end else begin
                  state_r[g] <= supply_limit_monitor_pkg::SEQ_ON_WAIT;
                end
              end
            end
            supply_limit_monitor_pkg::SEQ_ON_WAIT: begin
              if (stop) begin
                state_r[g] <= supply_limit_monitor_pkg::SEQ_OFF;
              end else if (ms_tick) begin
                if (tcnt_r + 16'd1 >= ton_d_r[g]) begin
                  state_r[g] <= supply_limit_monitor_pkg::SEQ_ON;
                  en_r[g]    <= 1'b1;
                  tcnt_r     <= 16'h0000;
                end else begin
                  tcnt_r <= tcnt_r + 16'd1;
                end
              end
            end
            supply_limit_monitor_pkg::SEQ_ON: begin
              if (stop) begin
                tcnt_r <= 16'h0000;
                if (toff_d_r[g] == 16'h0000) begin
                  state_r[g] <= supply_limit_monitor_pkg::SEQ_OFF;
                  en_r[g]    <= 1'b0;
                end else begin
                  state_r[g] <= supply_limit_monitor_pkg::SEQ_OFF_WAIT;
                end
              end else if (ton_evt[g]) begin
                ton_done_r <= 1'b1;
              end else if (ms_tick && !pg_seen_r[g] && !ton_done_r) begin
                tcnt_r <= tcnt_r + 16'd1;
              end
            end
            supply_limit_monitor_pkg::SEQ_OFF_WAIT: begin
              if (start) begin
                state_r[g] <= supply_limit_monitor_pkg::SEQ_ON;
              end else if (ms_tick) begin
                if (tcnt_r + 16'd1 >= toff_d_r[g]) begin
                  state_r[g] <= supply_limit_monitor_pkg::SEQ_OFF;
                  en_r[g]    <= 1'b0;
                end else begin
                  tcnt_r <= tcnt_r + 16'd1;
                end
              end
            end
            default: begin
              state_r[g] <= supply_limit_monitor_pkg::SEQ_OFF;
              en_r[g]    <= 1'b0;
            end
          endcase
        end
      end
      assign seq_off[g] = !en_r[g];
    end
  endgenerate

  // Summary word and alert source.
  always_comb begin
    logic v_any, i_any, oc_any, ov_any, alert_any;
    v_any     = 1'b0;
    i_any     = 1'b0;
    oc_any    = 1'b0;
    ov_any    = 1'b0;
    alert_any = 1'b0;
    for (int c = 0; c < N; c++) begin
      v_any  = v_any | (|vstat_r[c]);
      i_any  = i_any | (|istat_r[c]);
      oc_any = oc_any | istat_r[c][`IS_OC_FAULT];
      ov_any = ov_any | vstat_r[c][`VS_OV_FAULT];
    end
    status_word = 16'h0000;
    status_word[`SW_VOUT]      = v_any;
    status_word[`SW_IOUT]      = i_any;
    status_word[`SW_VENDOR]    = i_vendor_status_any;
    status_word[`SW_POWER_BAD] = |pbad_r;
    status_word[`SW_MARGIN]    = i_margin_fault;
    status_word[`SW_SEQ_OFF]   = |seq_off;
    status_word[`SW_OV_FAULT]  = ov_any;
    status_word[`SW_OC_FAULT]  = oc_any;
    status_word[`SW_TEMP]      = |tstat_r;
    status_word[`SW_COMM]      = i_comm_fault;
    alert_any = v_any | i_any | (|tstat_r);
    alert_src = alert_any;
  end

  // Read data for the selected page.
  always_comb begin
    case (i_cmd.code)
      `CMD_UV_FAULT_LIMIT: rd_nxt = uv_lim_r[pg_sel];
      `CMD_OC_WARN_LIMIT:  rd_nxt = ocw_lim_r[pg_sel];
      `CMD_OC_FAULT_LIMIT: rd_nxt = ocf_lim_r[pg_sel];
      `CMD_GOOD_ON:        rd_nxt = pgon_r[pg_sel];
      `CMD_GOOD_OFF:       rd_nxt = pgoff_r[pg_sel];
      `CMD_TURN_ON_DELAY:  rd_nxt = ton_d_r[pg_sel];
      `CMD_TURN_ON_LIMIT:  rd_nxt = ton_max_r[pg_sel];
      `CMD_TURN_OFF_DELAY: rd_nxt = toff_d_r[pg_sel];
      `CMD_PIN_CONFIG:     rd_nxt = pin_cfg_r[pg_sel];
      `CMD_OVERTEMP_FAULT_LIMIT: rd_nxt = otf_lim_r;
      `CMD_OVERTEMP_WARN_LIMIT:  rd_nxt = otw_lim_r;
      `CMD_VENDOR_MODE:    rd_nxt = mode_r;
      `CMD_FAULT_ACTION:   rd_nxt = action_r;
      `CMD_STATUS_WORD:    rd_nxt = status_word;
      `CMD_VOLTAGE_STATUS: rd_nxt = {8'h00, vstat_r[pg_sel]};
      `CMD_CURRENT_STATUS: rd_nxt = {8'h00, istat_r[pg_sel]};
      `CMD_TEMP_STATUS:    rd_nxt = {8'h00, tstat_r};
      default:             rd_nxt = 16'h0000;
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_rdata  <= 16'h0000;
      o_rvalid <= 1'b0;
    end else begin
      o_rvalid <= i_cmd.valid && !i_cmd.write;
      if (i_cmd.valid && !i_cmd.write) begin
        o_rdata <= rd_nxt;
      end
    end
  end

  // System outputs.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_supply_enable_out <= '0;
      o_margin_start      <= 1'b0;
      o_alert_oe          <= 1'b0;
      o_ara_enable        <= 1'b0;
    end else begin
      o_supply_enable_out <= en_r;
      o_margin_start      <= &pg_r;
      o_alert_oe          <= mode_r[`MODE_ALERT_BIT] && alert_src;
      o_ara_enable        <= mode_r[`MODE_ALERT_BIT];
    end
  end
endmodule

// [supply_limit_monitor_defines.svh]
`ifndef SUPPLY_LIMIT_MONITOR_DEFINES_SVH
`define SUPPLY_LIMIT_MONITOR_DEFINES_SVH
// Notes on behaviour
// - Undervoltage fault clears only once voltage is 2% above its limit.
// - Undervoltage detection masked until first power-good-on, and while turning off.
// - Undervoltage fault sets word bit 15, voltage bit 4, fault action, alert.
// - Overcurrent warning clears only once current is 5% below its limit.
// - Overcurrent warning sets word bit 14, current bit 5, alert; no fault action.
// - Overcurrent fault armed after current first below limit; clears 5% below.
// - Overcurrent fault sets word bit 14, current bit 7, fault action, alert.
// - Overtemperature fault sets bit 2, temperature bit 7, action, alert; 4 degree hysteresis.
// - Overtemperature warning sets bit 2, temperature bit 6, alert; 4 degree hysteresis.
// - Power-good only above good-on level; margining starts when all channels good.
// - Fall from above good-on to below good-off sets channel and word power-bad.
// - Enable output asserts after programmed turn-on delay in milliseconds.
// - Enable deasserts after turn-off delay; immediate-off bypasses the delay.
// - Delays on power-good or alarm outputs may run 2 to 3 ms longer.
// - Turn-on timeout sets bit 15, voltage bit 2, action, alert; zero disables.
// - Status word bits: 15 voltage, 14 current, 12 vendor, 8 margin, 2 temperature, 1 comms.
// - Word bit 6 is OR of off flags, bit 11 OR of power-bad flags.
// - Sequenced-off and power-bad bits never raise alert.
// - Voltage bits latch and re-set while condition persists; timeout only on new event.
// - Voltage byte: 7 ov fault, 6 ov warn, 5 uv warn, 4 uv fault, 2 timeout.
// - Current byte: 7 overcurrent fault, 5 warning; re-set while condition persists.
// - Status word bit 5 reports overvoltage fault, bit 4 overcurrent fault.
// - Alert output and alert response active only with mode bit 13 set.
// - Channel power-bad flag set from reset until first power-good-on.

`define CHANNELS           4
`define CHAN_W             2

`define CMD_OC_WARN_LIMIT  8'h46
`define CMD_OC_FAULT_LIMIT 8'h4a
`define CMD_OVERTEMP_FAULT_LIMIT 8'h4f
`define CMD_OVERTEMP_WARN_LIMIT  8'h51
`define CMD_GOOD_ON        8'h5e
`define CMD_GOOD_OFF       8'h5f
`define CMD_TURN_ON_DELAY  8'h60
`define CMD_TURN_ON_LIMIT  8'h62
`define CMD_TURN_OFF_DELAY 8'h64
`define CMD_STATUS_WORD    8'h79
`define CMD_VOLTAGE_STATUS 8'h7a
`define CMD_CURRENT_STATUS 8'h7b
`define CMD_TEMP_STATUS    8'h7d
`define CMD_UV_FAULT_LIMIT 8'h44
`define CMD_VENDOR_MODE    8'hd1
`define CMD_FAULT_ACTION   8'hd5
`define CMD_PIN_CONFIG     8'hd6

`define SW_VOUT            15
`define SW_IOUT            14
`define SW_VENDOR          12
`define SW_POWER_BAD       11
`define SW_MARGIN          8
`define SW_SEQ_OFF         6
`define SW_OV_FAULT        5
`define SW_OC_FAULT        4
`define SW_TEMP            2
`define SW_COMM            1

`define VS_OV_FAULT        7
`define VS_OV_WARN         6
`define VS_UV_WARN         5
`define VS_UV_FAULT        4
`define VS_TIMEOUT         2
`define IS_OC_FAULT        7
`define IS_OC_WARN         5
`define TS_OT_FAULT        7
`define TS_OT_WARN         6

`define MODE_ALERT_BIT     13
`define ACTION_SHUTDOWN    0
`define PIN_GOOD_MODE      0

`define LIMIT_RESET        16'h0000
`define MODE_RESET         16'h0000
`define VOLT_HYST_DIV      16'd50
`define CURR_HYST_DIV      16'd20
`define TEMP_HYST_DEG      16'h0004

`define CLK_PERIOD_NS      10
`define MS_TIME_NS         1000000
`define MS_CYCLES_DEFAULT  (`MS_TIME_NS / `CLK_PERIOD_NS)
`endif

// [supply_limit_monitor_pkg.sv]
`include "supply_limit_monitor_defines.svh"
package supply_limit_monitor_pkg;
  typedef enum logic [1:0] {MEAS_VOUT, MEAS_IOUT, MEAS_TEMP} meas_kind_t;

  typedef struct packed {
    logic              valid;
    meas_kind_t        kind;
    logic [`CHAN_W-1:0] chan;
    logic [15:0]       value;
  } meas_t;

  typedef struct packed {
    logic              valid;
    logic              write;
    logic [7:0]        code;
    logic [`CHAN_W-1:0] page;
    logic [15:0]       wdata;
  } cmd_t;

  typedef enum logic [1:0] {SEQ_OFF, SEQ_ON_WAIT, SEQ_ON, SEQ_OFF_WAIT} seq_state_t;
endpackage

// [supply_model.sv]
`timescale 1ns/1ps
module supply_model (
  input  wire logic                            i_core_clk,
  output supply_limit_monitor_pkg::meas_t      o_meas
);
  initial o_meas = '0;
  // One fresh conversion per call; the bus is scrambled once the sample is gone.
  task automatic put(input logic [1:0] k, input logic [1:0] c, input logic [15:0] v);
    o_meas = '{1'b1, supply_limit_monitor_pkg::meas_kind_t'(k), c, v};
    @(posedge i_core_clk);
    #1 o_meas = '{1'b0, supply_limit_monitor_pkg::meas_kind_t'(k), c, ~v};
    @(posedge i_core_clk);
    #1;
  endtask
endmodule

// [supply_limit_monitor_monitor.sv]
`timescale 1ns/1ps
module limit_checker (
  input wire logic                           i_core_clk,
  input wire logic                           i_rst,
  input wire supply_limit_monitor_pkg::cmd_t i_cmd,
  input wire logic                           i_immediate_off_pin,
  input wire logic [3:0]                     i_on_off_control_pins,
  input wire logic [15:0]                    o_rdata,
  input wire logic                           o_rvalid,
  input wire logic [3:0]                     o_supply_enable_out,
  input wire logic                           o_alert_oe,
  input wire logic                           o_ara_enable
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  AST_READ_ANSWER: assert property (i_cmd.valid && !i_cmd.write |=> o_rvalid) else $error("read not answered");
  AST_RVALID_QUIET: assert property (!i_cmd.valid |=> !o_rvalid) else $error("answer without read");
  AST_WORD_ZEROS: assert property (o_rvalid && $past(i_cmd.code) == 8'h79 |-> !(o_rdata & 16'h2689))
    else $error("status word reserved bit set");
  AST_VOUT_ZEROS: assert property (o_rvalid && $past(i_cmd.code) == 8'h7a |-> !(o_rdata & 16'hff0b))
    else $error("voltage byte reserved bit set");
  AST_IOUT_ZEROS: assert property (o_rvalid && $past(i_cmd.code) == 8'h7b |-> !(o_rdata & 16'hff5f))
    else $error("current byte reserved bit set");
  AST_TEMP_ZEROS: assert property (o_rvalid && $past(i_cmd.code) == 8'h7d |-> !(o_rdata & 16'hff3f))
    else $error("temperature byte reserved bit set");
  AST_ALERT_GATED: assert property (!o_ara_enable [*2] |-> !o_alert_oe) else $error("alert while disabled");
  AST_ARA_FOLLOWS: assert property (i_cmd.valid && i_cmd.write && i_cmd.code == 8'hd1
    |-> ##2 o_ara_enable == $past(i_cmd.wdata[13], 2)) else $error("alert enable not taken");
  AST_IMMEDIATE_OFF: assert property (i_immediate_off_pin [*6] |-> o_supply_enable_out == 4'h0)
    else $error("enable held during immediate off");
  AST_ENABLE_CAUSE: assert property ($rose(o_supply_enable_out[0]) |-> $past(i_on_off_control_pins[0], 2))
    else $error("enable without start");
endmodule
bind supply_limit_monitor limit_checker chk (.i_core_clk, .i_rst, .i_cmd, .i_immediate_off_pin,
  .i_on_off_control_pins, .o_rdata, .o_rvalid, .o_supply_enable_out, .o_alert_oe, .o_ara_enable);

// [supply_limit_monitor_tb.sv]
`timescale 1ns/1ps
module supply_limit_monitor_tb;
  logic i_core_clk = 1'b0, i_rst = 1'b1, o_rvalid, o_margin_start, o_alert_oe, o_ara_enable;
  logic i_vendor_status_any = 1'b0, i_margin_fault = 1'b0, i_comm_fault = 1'b0, i_immediate_off_pin = 1'b0;
  logic [3:0] i_ov_fault = 4'h0, i_ov_warn = 4'h0, i_uv_warn = 4'h0, i_on_off_control_pins = 4'h0;
  logic [3:0] o_supply_enable_out, o_fault_response;
  logic [15:0] o_rdata, r, exp_q[$];
  supply_limit_monitor_pkg::cmd_t i_cmd = '0;
  supply_limit_monitor_pkg::meas_t i_meas;
  int fails = 0, checked = 0;
  always #5 i_core_clk = ~i_core_clk;
  supply_limit_monitor #(.MS_CYCLES(10)) uut (.i_core_clk, .i_rst, .i_cmd, .o_rdata, .o_rvalid, .i_meas,
    .i_ov_fault, .i_ov_warn, .i_uv_warn, .i_vendor_status_any, .i_margin_fault, .i_comm_fault,
    .i_on_off_control_pins, .i_immediate_off_pin, .o_supply_enable_out, .o_fault_response, .o_margin_start,
    .o_alert_oe, .o_ara_enable);
  supply_model supply (.i_core_clk, .o_meas(i_meas));
  task automatic chk(input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("BAD %0t exp %h got %h", $time, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask
  task automatic cmd(input logic w, input logic [7:0] c, input logic [15:0] d);
    i_cmd = '{1'b1, w, c, 2'h0, d};
    tick(1);
    i_cmd.valid = 1'b0;
    tick(1);
  endtask
  task automatic rd(input logic [7:0] c, input logic [15:0] e);
    exp_q.push_back(e);
    cmd(1'b0, c, 16'h0000);
  endtask
  task automatic report_and_stop;
    if (exp_q.size() != 0) fails++;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge i_core_clk) if (o_rvalid === 1'b1) chk(exp_q.size() ? exp_q.pop_front() : 16'hxxxx, o_rdata);
  initial begin
    tick(3000);
    fails++;
    report_and_stop;
  end
  initial begin
    void'($urandom(32'hc1fd));
    tick(5);
    i_rst = 1'b0;
    rd(8'h79, 16'h0840);
    rd(8'h00, 16'h0000);
    r = 16'($urandom);
    cmd(1'b1, 8'h46, r);
    cmd(1'b1, 8'h79, 16'hffff);
    rd(8'h46, r);
    rd(8'h79, 16'h0840);
    $display("test access done");
    {i_vendor_status_any, i_margin_fault, i_comm_fault, i_ov_warn} = 7'h71;
    tick(3);
    rd(8'h79, 16'h9942);
    cmd(1'b1, 8'h7a, 16'h00ff);
    rd(8'h7a, 16'h0040);
    {i_vendor_status_any, i_margin_fault, i_comm_fault, i_ov_warn} = 7'h00;
    cmd(1'b1, 8'h7a, 16'h00ff);
    rd(8'h7a, 16'h0000);
    $display("test status word done");
    cmd(1'b1, 8'hd1, 16'h2000);
    cmd(1'b1, 8'h4a, 16'hffff);
    cmd(1'b1, 8'h46, 16'h03e8);
    supply.put(2'h1, 2'h0, 16'h044c);
    rd(8'h7b, 16'h0020);
    chk(16'h0001, {15'h0, o_alert_oe});
    supply.put(2'h1, 2'h0, 16'h03d4);
    cmd(1'b1, 8'h7b, 16'h00ff);
    rd(8'h7b, 16'h0020);
    supply.put(2'h1, 2'h0, 16'h03ac);
    cmd(1'b1, 8'h7b, 16'h00ff);
    rd(8'h7b, 16'h0000);
    $display("test current done");
    cmd(1'b1, 8'h4f, 16'h0100);
    cmd(1'b1, 8'h51, 16'h0050);
    supply.put(2'h2, 2'h0, 16'h0055);
    rd(8'h7d, 16'h0040);
    rd(8'h79, 16'h0844);
    supply.put(2'h2, 2'h0, 16'h004d);
    cmd(1'b1, 8'h7d, 16'h00ff);
    rd(8'h7d, 16'h0040);
    supply.put(2'h2, 2'h0, 16'h0046);
    cmd(1'b1, 8'h7d, 16'h00ff);
    rd(8'h7d, 16'h0000);
    tick(2);
    chk(16'h0000, {15'h0, o_alert_oe});
    supply.put(2'h2, 2'h0, 16'h0101);
    chk(16'h000f, {12'h0, o_fault_response});
    rd(8'h7d, 16'h00c0);
    cmd(1'b1, 8'h4a, 16'h0800);
    supply.put(2'h1, 2'h0, 16'h0900);
    chk(16'h0001, {12'h0, o_fault_response});
    rd(8'h7b, 16'h00a0);
    for (int c = 0; c < 4; c++) supply.put(2'h0, 2'(c), 16'h0100);
    chk(16'h0001, {15'h0, o_margin_start});
    rd(8'h79, 16'h4054);
    $display("test temperature done");
    cmd(1'b1, 8'h60, 16'h0003);
    i_on_off_control_pins = 4'h1;
    tick(15);
    chk(16'h0000, {12'h0, o_supply_enable_out});
    tick(30);
    chk(16'h0001, {12'h0, o_supply_enable_out});
    i_immediate_off_pin = 1'b1;
    tick(6);
    chk(16'h0000, {12'h0, o_supply_enable_out});
    $display("test sequencer done");
    report_and_stop;
  end
endmodule
